// *** logic/dacc_defines.vh ***
`ifndef DACC_DEFINES_VH
`define DACC_DEFINES_VH
// What this block does
// [RULE1] 32 channels, 1-cycle resolution, 8 staggered
// [RULE2] Four 16-bit reloadable timers, two per array
// [RULE3] Timer clock: prescaler or gp timer overflow
// [RULE4] First array timer may count external pin edges
// [RULE5] Sixteen channels per array, selectable timer, function
// [RULE6] Each channel owns one pin, input or output
// [RULE7] Mode 0: interrupt only, many per period
// [RULE8] Mode 1: pin toggles on every match
// [RULE9] Mode 2: interrupt only, once per period
// [RULE10] Mode 3: set on match, clear on overflow
// [RULE11] Double register: two channels toggle one pin
// [RULE12] Single event option stops after one event
// [RULE13] Capture latches allocated timer on pin edge
// [RULE14] Each capture raises its channel interrupt
// [RULE15] Capture edge: rising, falling or both
// [RULE16] Compare on every timer update, act on equal
// [RULE17] Timers count up, reload on overflow
// [RULE18] Edges from synchronised samples, one per cycle

// Sizes
`define DACC_CHANNELS 32
`define DACC_PER_ARRAY 16
`define DACC_TIMERS 4
`define DACC_TW 16
`define DACC_PRE_W 9
// Staggered mode adds this many prescaler bits (x8)
`define DACC_STAGGER_SH 3
// Timer top value before reload
`define DACC_TMR_TOP 16'hFFFF
// Reset values
`define DACC_TMR_RST 16'h0000
`define DACC_CC_RST 16'h0000
// Timer clock select codes (0..5 = prescale by 2^code)
`define DACC_CLK_GPT 3'h6
`define DACC_CLK_EXT 3'h7
// Compare mode codes
`define DACC_MODE0 2'h0
`define DACC_MODE1 2'h1
`define DACC_MODE2 2'h2
`define DACC_MODE3 2'h3
// Edge select codes
`define DACC_EDGE_RISE 2'h1
`define DACC_EDGE_FALL 2'h2
`define DACC_EDGE_BOTH 2'h3
`endif

// *** logic/dacc_capture_compare.v ***
`include "dacc_defines.vh"

module dacc_capture_compare (
   // Clock and reset
   input wire mclk,
   input wire rst,
   // Timer configuration, one run bit and three clock select bits per timer, timer a then b
   input wire [3:0] tmrRun,
   input wire [11:0] tmrClkSel,
   input wire staggerEn,
   // Timer value and reload writes
   input wire tmrWrEn,
   input wire relWrEn,
   input wire [1:0] tmrWrSel,
   input wire [15:0] tmrWrData,
   // Overflow pulse of the gp module two aux timer
   input wire gpAuxTimerOvf,
   // External count pins and edge select, one per array
   input wire [1:0] extCountPin,
   input wire [3:0] extEdgeSel,
   // Channel configuration
   input wire [31:0] chCapture,
   input wire [31:0] chTimerSel,
   input wire [63:0] chCmpMode,
   input wire [63:0] chEdgeSel,
   input wire [31:0] chSingle,
   input wire [15:0] dblPairEn,
   // Channel register write
   input wire ccWrEn,
   input wire [4:0] ccWrIdx,
   input wire [15:0] ccWrData,
   // Channel pins
   input wire [31:0] ccPinIn,
   output wire [31:0] ccPinOut,
   output wire [31:0] ccPinOeN,
   // Status
   output wire [511:0] ccValue,
   output wire [63:0] tmrValue,
   output wire [3:0] tmrOvfIrq,
   output wire [31:0] ccIrq
);

   // Pin synchroniser chain, channel pins plus two count pins
   reg [33:0] syn1Q;
   reg [33:0] syn2Q;
   reg [33:0] syn3Q;
   reg [33:0] stabQ;
   wire [33:0] stabD;
   wire [33:0] riseEdge;
   wire [33:0] fallEdge;
   // Free running prescaler
   reg [8:0] preQ;
   // Timer update and overflow, one cycle after the count
   // One driver per bit: each timer slice drives its own flops
   wire [3:0] updQ;
   wire [3:0] ovfQ;
   wire [63:0] tmrFlat;
   // Compare hits, seen by the pair partner
   wire [31:0] fire;

   // A change counts only once stages two and three agree
   assign stabD = (syn2Q & syn3Q) | (stabQ & (syn2Q ^ syn3Q)); // [RULE18]
   assign riseEdge = stabD & ~stabQ; // [RULE18]
   assign fallEdge = ~stabD & stabQ; // [RULE18]

   // Synchroniser and edge sample registers
   always @(posedge mclk) begin
      if (rst) begin
         syn1Q <= 34'h000000000;
         syn2Q <= 34'h000000000;
         syn3Q <= 34'h000000000;
         stabQ <= 34'h000000000;
      end else begin
         syn1Q <= {extCountPin, ccPinIn};
         syn2Q <= syn1Q;
         syn3Q <= syn2Q;
         stabQ <= stabD;
      end
   end

   // Prescaler runs always so all timers share one phase
   always @(posedge mclk) begin
      if (rst) begin
         preQ <= 9'h000;
      end else begin
         preQ <= preQ + 9'h001;
      end
   end

   genvar t;
   generate
      for (t = 0; t < `DACC_TIMERS; t = t + 1) begin : gTmr
         reg [15:0] valQ; // Running count
         reg [15:0] relQ; // Reload value
         reg [8:0] mask; // Prescaler bits that must be all ones
         reg tick; // Count enable this cycle
         reg extHit; // Selected external count edge
         reg updBitQ; // Update seen one cycle after the tick
         reg ovfBitQ; // Overflow seen one cycle after the tick
         wire [2:0] sel;
         wire [1:0] eSel;
         assign sel = tmrClkSel[3*t +: 3];
         assign eSel = extEdgeSel[2*(t/2) +: 2];
         assign tmrFlat[16*t +: 16] = valQ;
         assign updQ[t] = updBitQ;
         assign ovfQ[t] = ovfBitQ;

         // Clock source choice for this timer
         always @* begin
            mask = 9'h000;
            tick = 1'b0;
            case (eSel)
               `DACC_EDGE_RISE: extHit = riseEdge[32 + t/2];
               `DACC_EDGE_FALL: extHit = fallEdge[32 + t/2];
               `DACC_EDGE_BOTH: extHit = riseEdge[32 + t/2] | fallEdge[32 + t/2];
               default: extHit = 1'b0;
            endcase
            case (sel)
               `DACC_CLK_GPT: begin
                  tick = gpAuxTimerOvf; // [RULE3]
               end
               `DACC_CLK_EXT: begin
                  // Only the first timer of an array has a count pin
                  tick = (t % 2 == 0) ? extHit : 1'b0; // [RULE4]
               end
               default: begin
                  // Staggered mode slows the finest step to eight cycles
                  // Four-bit shift count so code 5 plus stagger does not wrap
                  mask = (9'h001 << ({1'b0, sel} + (staggerEn ? 4'h3 : 4'h0))) - 9'h001; // [RULE1]
                  tick = ((preQ & mask) == mask); // [RULE3]
               end
            endcase
            tick = tick & tmrRun[t];
         end

         // Count, reload and software writes
         always @(posedge mclk) begin
            if (rst) begin
               valQ <= `DACC_TMR_RST;
               relQ <= `DACC_TMR_RST;
               updBitQ <= 1'b0;
               ovfBitQ <= 1'b0;
            end else begin
               updBitQ <= tick;
               ovfBitQ <= tick && (valQ == `DACC_TMR_TOP);
               if (relWrEn && tmrWrSel == t) begin
                  relQ <= tmrWrData; // [RULE2]
               end
               if (tmrWrEn && tmrWrSel == t) begin
                  valQ <= tmrWrData;
               end else if (tick) begin
                  if (valQ == `DACC_TMR_TOP) begin
                     valQ <= relQ; // [RULE17]
                  end else begin
                     valQ <= valQ + 16'h0001; // [RULE17]
                  end
               end
            end
         end
      end
   endgenerate

   assign tmrValue = tmrFlat;
   assign tmrOvfIrq = ovfQ;

   genvar c;
   generate
      for (c = 0; c < `DACC_CHANNELS; c = c + 1) begin : gCh
         reg [15:0] ccQ; // Capture or compare value
         reg pinQ; // Output pin level
         reg irqQ; // Request pulse
         reg perDoneQ; // Event taken this period
         reg oneDoneQ; // Single event spent
         reg [15:0] tv; // Allocated timer value
         reg upd; // Allocated timer update
         reg ovf; // Allocated timer overflow
         reg capHit;
         reg hit;
         wire [1:0] mode;
         wire [1:0] eSel;
         wire lowHalf;
         wire pairOn;
         wire tgl;
         wire [1:0] ti;
         assign mode = chCmpMode[2*c +: 2];
         assign eSel = chEdgeSel[2*c +: 2];
         assign lowHalf = (c % 16) < 8;
         assign pairOn = dblPairEn[(c/16)*8 + (c%8)];
         // Array picks timer pair, channel picks a or b
         assign ti = {c / 16 == 1, chTimerSel[c]}; // [RULE5]
         assign fire[c] = hit;
         // Low channel of a pair toggles on either partner's match
         assign tgl = hit | (lowHalf & pairOn & fire[(c + 8) % 32]); // [RULE11]

         // Timer pick, edge pick and match decision
         always @* begin
            tv = tmrFlat[16*ti +: 16];
            upd = updQ[ti];
            ovf = ovfQ[ti];
            case (eSel)
               `DACC_EDGE_RISE: capHit = riseEdge[c]; // [RULE15]
               `DACC_EDGE_FALL: capHit = fallEdge[c]; // [RULE15]
               `DACC_EDGE_BOTH: capHit = riseEdge[c] | fallEdge[c]; // [RULE15]
               default: capHit = 1'b0;
            endcase
            capHit = capHit & chCapture[c] & ~oneDoneQ;
            // Modes 2 and 3 allow one event per period
            hit = ~chCapture[c] & upd & (tv == ccQ) & ~oneDoneQ
                  & ~(mode[1] & perDoneQ); // [RULE16] [RULE9]
         end

         // Channel register, flags, pin and request
         always @(posedge mclk) begin
            if (rst) begin
               ccQ <= `DACC_CC_RST;
               pinQ <= 1'b0;
               irqQ <= 1'b0;
               perDoneQ <= 1'b0;
               oneDoneQ <= 1'b0;
            end else begin
               irqQ <= capHit | hit; // [RULE14] [RULE7] [RULE9]
               // Capture wins over a software write in the same cycle
               if (capHit) begin
                  ccQ <= tv; // [RULE13]
               end else if (ccWrEn && ccWrIdx == c) begin
                  ccQ <= ccWrData;
               end
               // Period flag: a hit beats the overflow clear
               if (hit) begin
                  perDoneQ <= 1'b1; // [RULE9] [RULE10]
               end else if (ovf) begin
                  perDoneQ <= 1'b0;
               end
               // Single event holds until the option is dropped
               if (!chSingle[c]) begin
                  oneDoneQ <= 1'b0;
               end else if (hit | capHit) begin
                  oneDoneQ <= 1'b1; // [RULE12]
               end
               // Pin actions; a paired high channel leaves its pin
               if (chCapture[c] || (!lowHalf && pairOn)) begin
                  pinQ <= pinQ;
               end else if (lowHalf && pairOn) begin
                  if (tgl) begin
                     pinQ <= ~pinQ; // [RULE11]
                  end
               end else begin
                  case (mode)
                     `DACC_MODE1: begin
                        if (hit) begin
                           pinQ <= ~pinQ; // [RULE8]
                        end
                     end
                     `DACC_MODE3: begin
                        if (hit) begin
                           pinQ <= 1'b1; // [RULE10]
                        end else if (ovf) begin
                           pinQ <= 1'b0; // [RULE10]
                        end
                     end
                     default: begin
                        pinQ <= pinQ; // [RULE7]
                     end
                  endcase
               end
            end
         end

         // Pin is driven only in compare use
         reg oeNQ;
         always @(posedge mclk) begin
            if (rst) begin
               oeNQ <= 1'b1;
            end else begin
               oeNQ <= chCapture[c]; // [RULE6]
            end
         end

         assign ccValue[16*c +: 16] = ccQ;
         assign ccPinOut[c] = pinQ;
         assign ccPinOeN[c] = oeNQ;
         assign ccIrq[c] = irqQ;
      end
   endgenerate

endmodule

// *** verif/dacc_cc_properties.sv ***
`include "dacc_defines.vh"

module dacc_cc_properties (
   // Clock and reset
   input wire mclk,
   input wire rst,
   // Configuration
   input wire [3:0] tmrRun,
   input wire [11:0] tmrClkSel,
   input wire staggerEn,
   input wire tmrWrEn,
   input wire [31:0] chCapture,
   input wire [31:0] chTimerSel,
   input wire [63:0] chCmpMode,
   input wire [31:0] chSingle,
   input wire [15:0] dblPairEn,
   // Outputs
   input wire [31:0] ccPinOut,
   input wire [31:0] ccPinOeN,
   input wire [63:0] tmrValue,
   input wire [3:0] tmrOvfIrq,
   input wire [31:0] ccIrq
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // First time base of array one
   wire [15:0] t0Val = tmrValue[15:0];
   // Channel 4 already fired since its single option was raised
   logic singleFired_q;

   // Rearmed only by dropping the option, never by a timer wrap
   always @(posedge mclk) begin
      if (rst || !chSingle[4]) begin
         singleFired_q <= 1'b0;
      end else if (ccIrq[4]) begin
         singleFired_q <= 1'b1;
      end
   end

   oen_follows_a: assert property (!$past(rst) |-> ccPinOeN == $past(chCapture))
      else $error("pin enable not following function");
   ovf_from_top_a: assert property (tmrOvfIrq[0] |-> $past(t0Val) == `DACC_TMR_TOP)
      else $error("overflow without top value");
   step_by_one_a: assert property (!$past(rst) && !$past(tmrWrEn) && $changed(t0Val)
      && $past(t0Val) != `DACC_TMR_TOP |-> t0Val == $past(t0Val) + 16'h1)
      else $error("timer step not one");
   code0_ticks_a: assert property (!$past(rst) && $past(tmrRun[0] && tmrClkSel[2:0] == 3'h0
      && !staggerEn && !tmrWrEn) |-> $changed(t0Val))
      else $error("undivided clock missed a tick");
   toggle_on_hit_a: assert property (ccIrq[0] && $past(chCmpMode[1:0] == `DACC_MODE1
      && !chCapture[0] && !dblPairEn[0]) |-> ccPinOut[0] != $past(ccPinOut[0]))
      else $error("toggle mode pin unchanged");
   mode0_quiet_a: assert property (!$past(rst) && $past(chCmpMode[3:2] == `DACC_MODE0
      && !chCapture[1] && !dblPairEn[1]) && chCmpMode[3:2] == `DACC_MODE0 && !chCapture[1]
      |-> $stable(ccPinOut[1]))
      else $error("interrupt only mode moved pin");
   set_on_hit_a: assert property (ccIrq[3] && $past(chCmpMode[7:6] == `DACC_MODE3
      && !chCapture[3]) |-> ccPinOut[3])
      else $error("set mode pin not high on hit");
   clear_on_ovf_a: assert property (tmrOvfIrq[0] && !chTimerSel[3]
      && chCmpMode[7:6] == `DACC_MODE3 && !chCapture[3] |=> ccIrq[3] || !ccPinOut[3])
      else $error("set mode pin not cleared on overflow");
   single_shot_a: assert property (singleFired_q && chSingle[4] |-> !ccIrq[4])
      else $error("single event fired twice");
   pair_toggle_a: assert property (ccIrq[13] && !ccIrq[5] && $past(dblPairEn[5]
      && !chCapture[5] && !chCapture[13]) |-> ccPinOut[5] != $past(ccPinOut[5]))
      else $error("paired hit left pin unchanged");
   cover property (ccIrq[18]);
   cover property (tmrOvfIrq[0]);
   cover property (ccIrq[13]);
endmodule

bind dacc_capture_compare dacc_cc_properties i_props (.mclk(mclk), .rst(rst),
   .tmrRun(tmrRun), .tmrClkSel(tmrClkSel), .staggerEn(staggerEn), .tmrWrEn(tmrWrEn),
   .chCapture(chCapture), .chTimerSel(chTimerSel), .chCmpMode(chCmpMode),
   .chSingle(chSingle), .dblPairEn(dblPairEn), .ccPinOut(ccPinOut), .ccPinOeN(ccPinOeN),
   .tmrValue(tmrValue), .tmrOvfIrq(tmrOvfIrq), .ccIrq(ccIrq));

// *** verif/dacc_pin_partner.sv ***
module dacc_pin_partner (
   // Design pin drive
   input wire [31:0] ccPinOut,
   input wire [31:0] ccPinOeN,
   // Resolved pin level
   output wire [31:0] ccPinIn
);
   timeunit 1ns;
   timeprecision 100ps;
   // Levels the outside world puts on undriven pins
   logic [31:0] extLvl = 32'h0000_0000;
   // Driven pins read back the design's level, others the outside one
   assign ccPinIn = (~ccPinOeN & ccPinOut) | (ccPinOeN & extLvl);
   // Flip one outside level; caller keeps it for many cycles
   task flip(input int n);
      extLvl[n] = ~extLvl[n];
   endtask
endmodule

// *** verif/test_dual_array_capture_compare.sv ***
module test_dual_array_capture_compare;
   timeunit 1ns;
   timeprecision 100ps;
   // Expected interrupt vector, pin levels under mask, channel value
   typedef struct {logic [31:0] vec; logic [31:0] pin; logic [31:0] mask; int ch;
      logic [15:0] val;} dacc_note_t;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] tmrRun = 4'h0;
   logic [11:0] tmrClkSel = 12'h000;
   logic tmrWrEn = 1'b0;
   logic staggerEn = 1'b0;
   logic gpAuxTimerOvf = 1'b0;
   logic [1:0] extCountPin = 2'h0;
   logic [3:0] extEdgeSel = 4'h0;
   logic relWrEn = 1'b0;
   logic [1:0] tmrWrSel = 2'h0;
   logic [15:0] tmrWrData = 16'h0000;
   // Channels 16 to 18 capture, the rest compare
   logic [31:0] chCapture = 32'h0007_0000;
   logic [31:0] chTimerSel = 32'h0000_0000;
   logic [63:0] chCmpMode = 64'h0000_0000_0400_04E1;
   logic [63:0] chEdgeSel = 64'h0000_0039_0000_0000;
   logic [31:0] chSingle = 32'h0000_0010;
   logic [15:0] dblPairEn = 16'h0020;
   logic ccWrEn = 1'b0;
   logic [4:0] ccWrIdx = 5'h00;
   logic [15:0] ccWrData = 16'h0000;
   wire [31:0] ccPinIn, ccPinOut, ccPinOeN, ccIrq;
   wire [511:0] ccValue;
   wire [63:0] tmrValue;
   wire [3:0] tmrOvfIrq;
   int failures = 0;
   int checks = 0;
   logic [31:0] rnd = 32'h1CF5CBB6;
   logic [31:0] pinExp = 32'h0000_0000;
   dacc_note_t notes[$];
   dacc_note_t cur;

   always #50 mclk = ~mclk;

   dacc_capture_compare i_dut (.mclk(mclk), .rst(rst), .tmrRun(tmrRun),
      .tmrClkSel(tmrClkSel), .staggerEn(staggerEn), .tmrWrEn(tmrWrEn), .relWrEn(relWrEn),
      .tmrWrSel(tmrWrSel), .tmrWrData(tmrWrData), .gpAuxTimerOvf(gpAuxTimerOvf),
      .extCountPin(extCountPin), .extEdgeSel(extEdgeSel), .chCapture(chCapture),
      .chTimerSel(chTimerSel),
      .chCmpMode(chCmpMode), .chEdgeSel(chEdgeSel), .chSingle(chSingle),
      .dblPairEn(dblPairEn), .ccWrEn(ccWrEn), .ccWrIdx(ccWrIdx), .ccWrData(ccWrData),
      .ccPinIn(ccPinIn), .ccPinOut(ccPinOut), .ccPinOeN(ccPinOeN), .ccValue(ccValue),
      .tmrValue(tmrValue), .tmrOvfIrq(tmrOvfIrq), .ccIrq(ccIrq));

   dacc_pin_partner i_pins (.ccPinOut(ccPinOut), .ccPinOeN(ccPinOeN), .ccPinIn(ccPinIn));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %0t %s", $time, msg);
      end
   endtask

   task end_sim;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // One-cycle write pulses, driven on the falling edge
   task chWr(input logic [4:0] i, input logic [15:0] d);
      ccWrEn = 1'b1; ccWrIdx = i; ccWrData = d;
      @(negedge mclk);
      ccWrEn = 1'b0;
   endtask

   task tmWr(input logic rel, input logic [1:0] s, input logic [15:0] d);
      tmrWrEn = !rel; relWrEn = rel; tmrWrSel = s; tmrWrData = d;
      @(negedge mclk);
      tmrWrEn = 1'b0; relWrEn = 1'b0;
   endtask

   task note(input logic [31:0] v, input logic [31:0] m, input int c, input logic [15:0] x);
      notes.push_back('{v, pinExp, m, c, x});
   endtask

   // Each interrupt pulse is matched against the oldest note
   always @(negedge mclk) begin
      if (!rst && ccIrq !== 32'h0000_0000) begin
         if (notes.size() == 0) begin
            check(ccIrq, 32'h0000_0000, "unexpected interrupt");
         end else begin
            cur = notes.pop_front();
            check(ccIrq, cur.vec, "interrupt vector");
            check(ccPinOut & cur.mask, cur.pin & cur.mask, "pin level");
            check({16'h0000, ccValue[cur.ch*16 +: 16]}, {16'h0000, cur.val}, "value");
         end
      end
   end

   // Cut a hang short well past the expected run length
   initial begin
      #(5000 * 100);
      failures++;
      $display("FAIL %0t watchdog expired", $time);
      end_sim;
   end

   initial begin
      repeat (5) @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      check(ccPinOeN, chCapture, "pin enables");
      check(tmrValue[31:0], 32'h0000_0000, "timer reset");
      $display("test reset done");
      // Period of eight ticks from reload FFF8, hits at FFFA, FFFB, FFFD
      for (int i = 0; i < 5; i++) chWr(i[4:0], 16'hFFFA);
      chWr(5'd5, 16'hFFFB);
      chWr(5'd13, 16'hFFFD);
      tmWr(1'b1, 2'h0, 16'hFFF8);
      tmWr(1'b0, 2'h0, 16'hFFF8);
      for (int p = 0; p < 3; p++) begin
         pinExp[0] = ~pinExp[0];
         pinExp[3] = 1'b1;
         note((p == 0) ? 32'h1F : 32'h0F, 32'h29, 0, 16'hFFFA);
         pinExp[5] = ~pinExp[5];
         note(32'h20, 32'h29, 5, 16'hFFFB);
         pinExp[5] = ~pinExp[5];
         note(32'h2000, 32'h29, 13, 16'hFFFD);
      end
      tmrRun[0] = 1'b1;
      repeat (24) @(negedge mclk);
      tmrRun[0] = 1'b0;
      repeat (8) @(negedge mclk);
      check(notes.size(), 0, "compare hits missing");
      check(tmrValue[15:0], 16'hFFF8, "timer after wraps");
      check(ccPinOut[3], 1'b0, "set pin after overflow");
      $display("test compare done");
      // Rise, fall and both-edge capture on a frozen timer
      for (int e = 0; e < 3; e++) begin
         for (int h = 0; h < 2; h++) begin
            rnd = lfsr(rnd);
            tmWr(1'b0, 2'h2, rnd[15:0]);
            if (e == 2 || e == h) note(32'h1 << (16 + e), 32'h0, 16 + e, rnd[15:0]);
            i_pins.flip(16 + e);
            repeat (8) @(negedge mclk);
         end
      end
      check(notes.size(), 0, "captures missing");
      $display("test capture done");
      // Staggered finest step: one tick per eight cycles on timer b of array one
      tmrClkSel[5:3] = 3'h0;
      staggerEn = 1'b1;
      tmrRun[1] = 1'b1;
      repeat (64) @(negedge mclk);
      tmrRun[1] = 1'b0;
      staggerEn = 1'b0;
      @(negedge mclk);
      check({16'h0000, tmrValue[31:16]}, 32'h0000_0008, "staggered ticks");
      // Gp aux timer overflow pulses clock the same timer
      tmrClkSel[5:3] = `DACC_CLK_GPT;
      tmrRun[1] = 1'b1;
      for (int g = 0; g < 3; g++) begin
         gpAuxTimerOvf = 1'b1;
         @(negedge mclk);
         gpAuxTimerOvf = 1'b0;
         repeat (2) @(negedge mclk);
      end
      tmrRun[1] = 1'b0;
      check({16'h0000, tmrValue[31:16]}, 32'h0000_000B, "gp overflow ticks");
      // Rising edges on the array two count pin clock its first timer
      tmWr(1'b0, 2'h2, 16'h0010);
      tmrClkSel[8:6] = `DACC_CLK_EXT;
      extEdgeSel[3:2] = `DACC_EDGE_RISE;
      tmrRun[2] = 1'b1;
      for (int k = 0; k < 3; k++) begin
         extCountPin[1] = 1'b1;
         repeat (6) @(negedge mclk);
         extCountPin[1] = 1'b0;
         repeat (6) @(negedge mclk);
      end
      tmrRun[2] = 1'b0;
      check({16'h0000, tmrValue[47:32]}, 32'h0000_0013, "external count ticks");
      $display("test clocks done");
      end_sim;
   end
endmodule
